//--- ir_transceiver_serial_control_bench.sv
// self-checking bench: controller and transceiver joined over the serial link
`timescale 1ns/1ns
module ir_transceiver_serial_control_bench;
   import irsc_pkg::*;
   localparam logic [7:0] MFR = 8'h5a; // arbitrary value
   localparam logic [7:0] DEV = 8'ha5; // arbitrary value
   localparam logic [7:0] MASK = 8'h3c; // arbitrary value
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic acknowledge_enable = 1'b1;
   logic [7:0] power_ctrl, rx_mode, led_level;
   logic frame_busy;
   logic [31:0] q;
   logic [31:0] d;
   logic [8:0] e;
   logic [7:0] ext_list [10] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
      8'hf0, 8'h02, 8'hff};
   integer failures = 0;
   integer n_checks = 0;
   integer seed = 67;
   integer model [0:2] = '{15, 0, 112};
   irsc_link_if link ();
   always #2 clock = ~clock;
   irsc_host irsc_host_i (.clock(clock), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link.host));
   irsc_device #(.MFR_ID(MFR), .DEV_ID(DEV), .MASK_ID(MASK)) irsc_device_i (.clock(clock),
      .srst(srst), .link(link.dev), .acknowledge_enable(acknowledge_enable),
      .power_ctrl(power_ctrl), .rx_mode(rx_mode), .led_level(led_level), .frame_busy(frame_busy));
   irsc_link_checker irsc_link_checker_i (.clock(clock), .srst(srst), .sclk(link.sclk),
      .serial_write_line(link.serial_write_line), .serial_read_line(link.serial_read_line));
   // ==========================================
   // tasks
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      @(posedge clock);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // leaves the final status word in q
   task frame(input irsc_cmd_type k, input logic [3:0] idx, input logic [2:0] a,
      input logic [7:0] v);
      bus(1'b1, 4'h0, {8'h00, v, 6'h00, a, idx, k});
      do bus(1'b0, 4'h4, 32'h0000_0000); while (q[1] !== 1'b1);
   endtask
   function automatic logic [8:0] ext_exp(input logic [7:0] i);
      case (i)
         8'h00: return {1'b1, MFR};
         8'h01: return {1'b1, DEV};
         8'h04: return 9'h123;
         8'h05: return 9'h130;
         8'h06: return 9'h103;
         8'h07: return 9'h12f;
         8'h08: return 9'h101;
         8'hf0: return {1'b1, MASK};
         default: return 9'h000;
      endcase
   endfunction
   task results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #300000;
      failures = failures + 1;
      results;
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      foreach (ext_list[i]) begin
         e = ext_exp(ext_list[i]);
         // an unanswered read leaves the line high, so the host shifts in all ones
         e[7:0] = e[8] ? e[7:0] : 8'hff;
         frame(IRSC_CMD_EXT_READ, 4'hf, 3'h2, ext_list[i]);
         check({31'h0, q[3]}, 32'h0000_0001);
         bus(1'b0, 4'h8, 32'h0000_0000);
         check({24'h0, q[7:0]}, {24'h0, e[7:0]});
      end
      $display("test 1 done");
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         acknowledge_enable <= i[0];
         frame(IRSC_CMD_WRITE, 4'h2, 3'h2, d[7:0]);
         model[2] = d[7:0];
         check({31'h0, q[2]}, {31'h0, i[0]});
         check({24'h0, led_level}, model[2]);
      end
      frame(IRSC_CMD_READ, 4'h2, 3'h2, 8'h00);
      check({31'h0, q[3]}, 32'h0000_0001);
      bus(1'b0, 4'h8, 32'h0000_0000);
      check({24'h0, q[7:0]}, model[2]);
      check({31'h0, frame_busy}, 32'h0000_0000);
      $display("test 2 done");
      frame(IRSC_CMD_READ, 4'h2, 3'h7, 8'h00);
      bus(1'b0, 4'h8, 32'h0000_0000);
      check({24'h0, q[7:0]}, 32'h0000_00ff);
      frame(IRSC_CMD_WRITE, 4'h2, 3'h1, ~d[7:0]);
      check({31'h0, q[2]}, 32'h0000_0000);
      frame(IRSC_CMD_WRITE, 4'h5, 3'h2, ~d[7:0]);
      check({31'h0, q[2]}, 32'h0000_0000);
      check({24'h0, led_level}, model[2]);
      frame(IRSC_CMD_WRITE, 4'h1, 3'h2, 8'h05);
      check({23'h0, q[2], rx_mode}, 32'h0000_0105);
      frame(IRSC_CMD_WRITE, 4'h1, 3'h2, 8'h04);
      check({23'h0, q[2], rx_mode}, 32'h0000_0000);
      $display("test 3 done");
      frame(IRSC_CMD_WRITE, 4'h0, 3'h2, 8'h00);
      frame(IRSC_CMD_LINE_RESET, 4'h0, 3'h0, 8'h00);
      check({8'h00, power_ctrl, rx_mode, led_level}, 32'h000f_0070);
      frame(IRSC_CMD_READ, 4'h0, 3'h2, 8'h00);
      bus(1'b0, 4'h8, 32'h0000_0000);
      check({24'h0, q[7:0]}, 32'h0000_000f);
      frame(IRSC_CMD_WRITE, 4'h2, 3'h2, 8'hf0);
      frame(IRSC_CMD_SPECIAL_RESET, 4'hd, 3'h7, 8'h00);
      check({24'h0, led_level}, 32'h0000_0070);
      bus(1'b0, 4'hc, 32'h0000_0000);
      check(q, 32'h0000_0000);
      $display("test 4 done");
      results;
   end
endmodule

//--- irsc_device.sv
// transceiver end of the serial control link
`timescale 1ns/1ns
`include "irsc_params.svh"
module irsc_device
   import irsc_pkg::*;
#(
   // identification bytes: values are arbitrary
   parameter logic [7:0] MFR_ID = 8'h5A,
   parameter logic [7:0] DEV_ID = 8'hA5,
   parameter logic [7:0] MASK_ID = 8'h3C,
   parameter int LOW_RESET = `IRSC_LOW_RESET_CLOCKS
)
(
   input wire logic clock,
   input wire logic srst,
   irsc_link_if.dev link,
   input wire logic acknowledge_enable,
   output logic [7:0] power_ctrl,
   output logic [7:0] rx_mode,
   output logic [7:0] led_level,
   output logic frame_busy
);

   generate
      if (LOW_RESET < 2 || LOW_RESET > 250) begin : g_bad_low_reset
         $error("LOW_RESET out of range");
      end
   endgenerate

   // ==========================================================
   // pin synchronisers and serial clock edge
   // ==========================================================
   logic sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
   logic wr_s1_reg, wr_s2_reg;
   logic rise;
   logic bit_in;

   always_ff @(posedge clock) begin
      if (srst) begin
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sclk_d_reg <= 1'b0;
         wr_s1_reg <= 1'b1;
         wr_s2_reg <= 1'b1;
      end else begin
         sclk_s1_reg <= link.sclk;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_d_reg <= sclk_s2_reg;
         wr_s1_reg <= link.serial_write_line;
         wr_s2_reg <= wr_s1_reg;
      end
   end

   // both lines see the same delay, so data set up before the rise is what we take
   assign rise = sclk_s2_reg & ~sclk_d_reg;
   assign bit_in = wr_s2_reg;

   // ==========================================================
   // long low on the write line
   // ==========================================================
   logic [7:0] low_cnt_reg;
   logic line_reset;

   always_ff @(posedge clock) begin
      if (srst) begin
         low_cnt_reg <= 8'h00;
      end else if (rise) begin
         if (bit_in) begin
            low_cnt_reg <= 8'h00;
         end else if (low_cnt_reg != 8'(LOW_RESET)) begin
            low_cnt_reg <= low_cnt_reg + 8'h01;
         end
      end
   end

   // fires once per low run; saturation keeps a held-low line from re-firing
   assign line_reset = rise & ~bit_in & (low_cnt_reg == 8'(LOW_RESET - 1));

   // ==========================================================
   // frame decode helpers
   // ==========================================================
   irsc_dev_state_type state_reg;
   logic [7:0] hdr_reg;
   logic [7:0] byte_reg;
   logic [3:0] cnt_reg;
   logic bad_reg;
   logic [7:0] hdr_next;
   logic [7:0] byte_next;
   logic dir_write;
   logic [3:0] idx;
   logic [2:0] addr;
   logic addr_write_ok;
   logic addr_read_ok;
   logic [8:0] read_value;
   logic write_ok;
   logic stop_done;
   logic turn_done;

   // fields arrive lsb first, so shifting in at the top leaves them in order
   assign hdr_next = {bit_in, hdr_reg[7:1]};
   assign byte_next = {bit_in, byte_reg[7:1]};
   assign dir_write = hdr_reg[0];
   assign idx = hdr_reg[4:1];
   assign addr = hdr_reg[7:5];
   assign addr_write_ok = (addr == `IRSC_OWN_ADDR) || (addr == `IRSC_BCAST_ADDR);
   // broadcast reads would have several devices answering on one line
   assign addr_read_ok = (addr == `IRSC_OWN_ADDR);

   function automatic logic [8:0] ext_lookup(input logic [7:0] ei);
      logic [8:0] r;
      r = 9'h000;
      unique case (ei)
         `IRSC_EXT_MFR: r = {1'b1, MFR_ID};
         `IRSC_EXT_DEV: r = {1'b1, DEV_ID};
         `IRSC_EXT_RECOVERY: r = {1'b1, `IRSC_VAL_RECOVERY};
         `IRSC_EXT_STABLE: r = {1'b1, `IRSC_VAL_STABLE};
         `IRSC_EXT_CAPS: r = {1'b1, `IRSC_VAL_CAPS};
         `IRSC_EXT_MODES_A: r = {1'b1, `IRSC_VAL_MODES_A};
         `IRSC_EXT_MODES_B: r = {1'b1, `IRSC_VAL_MODES_B};
         `IRSC_EXT_MASK: r = {1'b1, MASK_ID};
         default: r = 9'h000;
      endcase
      return r;
   endfunction

   function automatic logic mode_ok(input logic [7:0] m);
      return (m == 8'h00) || (m == 8'h01) || (m == 8'h02) || (m == 8'h03) ||
         (m == 8'h05) || (m == 8'h08);
   endfunction

   always_comb begin
      read_value = 9'h000;
      if (idx == `IRSC_IDX_ESCAPE) begin
         read_value = ext_lookup(byte_reg);
      end else if (idx == `IRSC_IDX_MAIN0) begin
         read_value = {1'b1, power_ctrl};
      end else if (idx == `IRSC_IDX_MAIN1) begin
         read_value = {1'b1, rx_mode};
      end else if (idx == `IRSC_IDX_MAIN2) begin
         read_value = {1'b1, led_level};
      end
   end

   assign write_ok = addr_write_ok & ~bad_reg &
      ((idx == `IRSC_IDX_MAIN0) || (idx == `IRSC_IDX_MAIN2) ||
       ((idx == `IRSC_IDX_MAIN1) & mode_ok(byte_reg)));
   assign stop_done = (state_reg == DS_STOP) & rise & (cnt_reg == 4'h1);
   assign turn_done = (state_reg == DS_TURN) & rise & (cnt_reg == 4'(`IRSC_TURN_CLOCKS));

   // ==========================================================
   // frame state
   // ==========================================================
   always_ff @(posedge clock) begin
      if (srst || line_reset) begin
         state_reg <= DS_IDLE;
         hdr_reg <= 8'h00;
         byte_reg <= 8'h00;
         cnt_reg <= 4'h0;
         bad_reg <= 1'b0;
      end else if (rise) begin
         cnt_reg <= cnt_reg + 4'h1;
         unique case (state_reg)
            DS_IDLE: begin
               if (!bit_in) begin
                  state_reg <= DS_SYNC;
               end
            end
            DS_SYNC: begin
               if (bit_in) begin
                  state_reg <= DS_HDR;
                  cnt_reg <= 4'h0;
                  bad_reg <= 1'b0;
               end
            end
            DS_HDR: begin
               hdr_reg <= hdr_next;
               if (cnt_reg == 4'h7) begin
                  cnt_reg <= 4'h0;
                  // format chosen from direction and index
                  if (hdr_next[0] && hdr_next[4:1] == `IRSC_IDX_SPECIAL) begin
                     state_reg <= DS_STOP;
                  end else if (hdr_next[0] || hdr_next[4:1] == `IRSC_IDX_ESCAPE) begin
                     state_reg <= DS_MARK;
                  end else begin
                     state_reg <= DS_TURN;
                  end
               end
            end
            DS_MARK: begin
               bad_reg <= ~bit_in;
               cnt_reg <= 4'h0;
               state_reg <= dir_write ? DS_DATA : DS_EIDX;
            end
            DS_DATA, DS_EIDX: begin
               byte_reg <= byte_next;
               if (cnt_reg == 4'h7) begin
                  cnt_reg <= 4'h0;
                  state_reg <= (state_reg == DS_DATA) ? DS_STOP : DS_TURN;
               end
            end
            DS_STOP: begin
               if (cnt_reg == 4'h1) begin
                  if (idx != `IRSC_IDX_SPECIAL && write_ok && acknowledge_enable) begin
                     state_reg <= DS_ACK;
                  end else begin
                     state_reg <= DS_IDLE;
                  end
               end
            end
            DS_ACK: state_reg <= DS_IDLE;
            DS_TURN: begin
               // start clock plus three high clocks before the first data bit
               if (cnt_reg == 4'(`IRSC_TURN_CLOCKS)) begin
                  cnt_reg <= 4'h0;
                  if (addr_read_ok && read_value[8] && !bad_reg) begin
                     state_reg <= DS_RESP;
                  end else begin
                     state_reg <= DS_IDLE;
                  end
               end
            end
            DS_RESP: begin
               if (cnt_reg == 4'h7) begin
                  state_reg <= DS_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // control registers
   // ==========================================================
   always_ff @(posedge clock) begin
      if (srst || line_reset) begin
         power_ctrl <= `IRSC_RST_MAIN0;
         rx_mode <= `IRSC_RST_MAIN1;
         led_level <= `IRSC_RST_MAIN2;
      end else if (stop_done && addr_write_ok) begin
         if (idx == `IRSC_IDX_SPECIAL) begin
            power_ctrl <= `IRSC_RST_MAIN0;
            rx_mode <= `IRSC_RST_MAIN1;
            led_level <= `IRSC_RST_MAIN2;
         end else if (!bad_reg) begin
            // other indices fall through untouched
            if (idx == `IRSC_IDX_MAIN0) begin
               power_ctrl <= byte_reg;
            end else if (idx == `IRSC_IDX_MAIN2) begin
               led_level <= byte_reg;
            end else if (idx == `IRSC_IDX_MAIN1) begin
               // an unsupported mode parks the receiver in the default mode
               rx_mode <= mode_ok(byte_reg) ? byte_reg : 8'h00;
            end
         end
      end
   end

   // ==========================================================
   // read line driver
   // ==========================================================
   logic [7:0] out_shift_reg;
   logic rd_line_reg;

   always_ff @(posedge clock) begin
      if (srst || line_reset) begin
         out_shift_reg <= 8'h00;
         rd_line_reg <= 1'b1;
      end else if (rise) begin
         if (stop_done && state_reg == DS_STOP && idx != `IRSC_IDX_SPECIAL &&
             write_ok && acknowledge_enable) begin
            rd_line_reg <= 1'b0;
         end else if (turn_done && addr_read_ok && read_value[8] && !bad_reg) begin
            rd_line_reg <= read_value[0];
            out_shift_reg <= {1'b1, read_value[7:1]};
         end else if (state_reg == DS_RESP && cnt_reg != 4'h7) begin
            rd_line_reg <= out_shift_reg[0];
            out_shift_reg <= {1'b1, out_shift_reg[7:1]};
         end else begin
            rd_line_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         frame_busy <= 1'b0;
      end else begin
         frame_busy <= (state_reg != DS_IDLE);
      end
   end

   assign link.serial_read_line = rd_line_reg;
endmodule

//--- irsc_host.sv
// controller end: avalon-mm command registers driving the serial control link
`timescale 1ns/1ns
`include "irsc_params.svh"
module irsc_host
   import irsc_pkg::*;
#(
   parameter int SCLK_PERIOD = `IRSC_SCLK_PERIOD_CYC
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   irsc_link_if.host link
);

   generate
      if (SCLK_PERIOD < `IRSC_SCLK_PERIOD_CYC || SCLK_PERIOD > 1024) begin : g_bad_period
         $error("SCLK_PERIOD too short or too long");
      end
   endgenerate

   localparam logic [9:0] HALF = 10'(SCLK_PERIOD / 2);

   // ==========================================================
   // read line synchroniser
   // ==========================================================
   logic rx_s1_reg, rx_s2_reg;

   always_ff @(posedge clock) begin
      if (srst) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
      end else begin
         rx_s1_reg <= link.serial_read_line;
         rx_s2_reg <= rx_s1_reg;
      end
   end

   // ==========================================================
   // avalon slave
   // ==========================================================
   irsc_host_state_type state_reg;
   logic take;
   logic start;
   logic done_reg, ack_reg, rvalid_reg;
   logic [7:0] rdata_reg;
   irsc_cmd_type kind;

   // one wait cycle on every access; the request completes on the second edge
   assign take = (avs_read | avs_write) & ~avs_waitrequest;
   assign start = take & avs_write & (avs_address[3:2] == `IRSC_REG_CMD) &
      (state_reg == HS_IDLE);
   assign kind = irsc_cmd_type'(avs_writedata[2:0]);

   always_ff @(posedge clock) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read & avs_waitrequest) begin
            unique case (avs_address[3:2])
               `IRSC_REG_STATUS: avs_readdata <= {28'h000_0000, rvalid_reg, ack_reg,
                  done_reg, state_reg != HS_IDLE};
               `IRSC_REG_RDATA: avs_readdata <= {24'h00_0000, rdata_reg};
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // frame builder and bit engine
   // ==========================================================
   logic [31:0] frame_reg;
   logic [5:0] len_reg, pos_reg, resp_reg, ack_pos_reg;
   logic [9:0] div_reg;
   logic sclk_reg, wline_reg;
   logic [9:0] hdr;
   logic [3:0] cmd_idx;
   logic cmd_dir;

   always_comb begin
      cmd_idx = avs_writedata[6:3];
      cmd_dir = 1'b0;
      unique case (kind)
         IRSC_CMD_WRITE: cmd_dir = 1'b1;
         IRSC_CMD_SPECIAL_RESET: begin
            cmd_dir = 1'b1;
            cmd_idx = `IRSC_IDX_SPECIAL;
         end
         IRSC_CMD_EXT_READ: cmd_idx = `IRSC_IDX_ESCAPE;
         default: cmd_dir = 1'b0;
      endcase
   end

   // sync 0 then 1, direction, index, address, each lsb first
   assign hdr = {avs_writedata[9:7], cmd_idx, cmd_dir, 2'b10};

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= HS_IDLE;
         frame_reg <= 32'hFFFF_FFFF;
         len_reg <= 6'd0;
         pos_reg <= 6'd0;
         resp_reg <= 6'd63;
         ack_pos_reg <= 6'd63;
         div_reg <= 10'd0;
         sclk_reg <= 1'b0;
         wline_reg <= 1'b1;
      end else begin
         unique case (state_reg)
            HS_IDLE: begin
               sclk_reg <= 1'b0;
               wline_reg <= 1'b1;
               if (start) begin
                  state_reg <= HS_LOW;
                  pos_reg <= 6'd0;
                  div_reg <= 10'd0;
                  resp_reg <= 6'd63;
                  ack_pos_reg <= 6'd63;
                  unique case (kind)
                     IRSC_CMD_WRITE: begin
                        frame_reg <= {11'h7FF, 2'b00, avs_writedata[23:16], 1'b1, hdr};
                        len_reg <= 6'd22;
                        ack_pos_reg <= 6'd21;
                     end
                     IRSC_CMD_READ: begin
                        // one low start clock, then high through the response
                        frame_reg <= {18'h3_FFFF, 3'b111, 1'b0, hdr[9:0]};
                        len_reg <= 6'd22;
                        resp_reg <= 6'd14;
                     end
                     IRSC_CMD_EXT_READ: begin
                        frame_reg <= {9'h1FF, 3'b111, 1'b0, avs_writedata[23:16], 1'b1,
                           hdr};
                        len_reg <= 6'd31;
                        resp_reg <= 6'd23;
                     end
                     IRSC_CMD_SPECIAL_RESET: begin
                        frame_reg <= {20'hF_FFFF, 2'b00, hdr};
                        len_reg <= 6'd12;
                     end
                     default: begin
                        frame_reg <= 32'h0000_0000;
                        len_reg <= 6'd32;
                     end
                  endcase
               end
            end
            HS_LOW: begin
               sclk_reg <= 1'b0;
               wline_reg <= frame_reg[pos_reg[4:0]];
               div_reg <= div_reg + 10'd1;
               if (div_reg == HALF - 10'd1) begin
                  div_reg <= 10'd0;
                  sclk_reg <= 1'b1;
                  state_reg <= HS_HIGH;
               end
            end
            HS_HIGH: begin
               div_reg <= div_reg + 10'd1;
               if (div_reg == HALF - 10'd1) begin
                  div_reg <= 10'd0;
                  sclk_reg <= 1'b0;
                  pos_reg <= pos_reg + 6'd1;
                  state_reg <= (pos_reg == len_reg - 6'd1) ? HS_IDLE : HS_LOW;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // answer capture, sampled at the rising edge the host makes
   // ==========================================================
   logic rise_now;
   assign rise_now = (state_reg == HS_LOW) & (div_reg == HALF - 10'd1);

   always_ff @(posedge clock) begin
      if (srst || start) begin
         done_reg <= 1'b0;
         ack_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= srst ? 8'h00 : rdata_reg;
      end else begin
         if (rise_now && pos_reg >= resp_reg && pos_reg < resp_reg + 6'd8) begin
            rdata_reg <= {rx_s2_reg, rdata_reg[7:1]};
            if (pos_reg == resp_reg + 6'd7) begin
               rvalid_reg <= 1'b1;
            end
         end
         if (rise_now && pos_reg == ack_pos_reg) begin
            ack_reg <= ~rx_s2_reg;
         end
         if (state_reg == HS_HIGH && div_reg == HALF - 10'd1 && pos_reg == len_reg - 6'd1) begin
            done_reg <= 1'b1;
         end
      end
   end

   assign link.sclk = sclk_reg;
   assign link.serial_write_line = wline_reg;
endmodule

//--- irsc_link_checker.sv
// assertions on the serial link between controller and transceiver
`timescale 1ns/1ns
module irsc_link_checker (
   input wire logic clock,
   input wire logic srst,
   input wire logic sclk,
   input wire logic serial_write_line,
   input wire logic serial_read_line
);
   logic [8:0] low_cnt_reg;
   logic [6:0] idle_cnt_reg;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // ==========================================
   // helper counters
   always_ff @(posedge clock) begin
      if (srst || serial_read_line) begin
         low_cnt_reg <= 9'h000;
      end else if (low_cnt_reg != 9'h1ff) begin
         low_cnt_reg <= low_cnt_reg + 9'h001;
      end
   end
   always_ff @(posedge clock) begin
      if (srst || sclk) begin
         idle_cnt_reg <= 7'h00;
      end else if (idle_cnt_reg != 7'h7f) begin
         idle_cnt_reg <= idle_cnt_reg + 7'h01;
      end
   end
   // ==========================================
   // link properties
   sequence s_high8;
      sclk [*8];
   endsequence
   sequence s_low8;
      !sclk [*8];
   endsequence
   a_reset_idle_lines: assert property ($fell(srst) |->
      !sclk && serial_write_line && serial_read_line)
      else $error("link lines not idle after reset");
   a_sclk_high_phase: assert property ($rose(sclk) |-> s_high8)
      else $error("serial clock high phase too short");
   a_sclk_low_phase: assert property ($fell(sclk) |-> s_low8)
      else $error("serial clock low phase too short");
   a_write_line_hold: assert property ($rose(sclk) |-> $stable(serial_write_line) [*3])
      else $error("write line moved around the sampling edge");
   a_read_change_when: assert property ($changed(serial_read_line) |->
      sclk && $past(sclk, 2))
      else $error("read line changed outside the high phase");
   a_read_bit_hold: assert property ($changed(serial_read_line) |=>
      $stable(serial_read_line) [*8])
      else $error("read line bit too short");
   a_read_low_bound: assert property (low_cnt_reg < 9'h120)
      else $error("read line held low too long");
   a_idle_lines_high: assert property (idle_cnt_reg == 7'h7f |->
      serial_read_line && serial_write_line)
      else $error("line not released between frames");
endmodule

//--- irsc_link_if.sv
// serial clock, write line and read line between controller and transceiver
`timescale 1ns/1ns
interface irsc_link_if;
   logic sclk;
   logic serial_write_line;
   logic serial_read_line;

   modport dev (
      input sclk,
      input serial_write_line,
      output serial_read_line
   );

   modport host (
      output sclk,
      output serial_write_line,
      input serial_read_line
   );
endinterface

//--- irsc_params.svh
// constants shared by both ends of the transceiver serial control link
`ifndef IRSC_PARAMS_SVH
`define IRSC_PARAMS_SVH
// Summary of operation
// - index all ones escapes to extended index
// - eight-bit extended index, then start plus three clocks
// - controller sends one low, then high throughout
// - device returns eight bits, bit 0 first
// - index one device id, zero manufacturer id
// - index 240 returns mask revision byte
// - indices seven, eight return supported mode bitmaps
// - unencodable commands discarded, no state change; an unsupported mode write to index one sets rx_mode to 8'h00
// - thirty low clocks reset state and registers
// - invalid write never acknowledged
// - invalid read starts no response
// - broadcast read gets no response
// - direction bit one write, zero read
// - serial clock period above 125 ns
// - write line sampled on serial clock rise
// - serial clock plus two one-way lines
// - four command formats accepted
// - answer only own address and broadcast
// - all fields sent least significant bit first
// - header sync 0,1, direction, index, address

`define IRSC_OWN_ADDR 3'h2
`define IRSC_BCAST_ADDR 3'h7
`define IRSC_IDX_MAIN0 4'h0
`define IRSC_IDX_MAIN1 4'h1
`define IRSC_IDX_MAIN2 4'h2
`define IRSC_IDX_SPECIAL 4'hD
`define IRSC_IDX_ESCAPE 4'hF

`define IRSC_EXT_MFR 8'h00
`define IRSC_EXT_DEV 8'h01
`define IRSC_EXT_RECOVERY 8'h04
`define IRSC_EXT_STABLE 8'h05
`define IRSC_EXT_CAPS 8'h06
`define IRSC_EXT_MODES_A 8'h07
`define IRSC_EXT_MODES_B 8'h08
`define IRSC_EXT_MASK 8'hF0
`define IRSC_VAL_RECOVERY 8'h23
`define IRSC_VAL_STABLE 8'h30
`define IRSC_VAL_CAPS 8'h03
`define IRSC_VAL_MODES_A 8'h2F
`define IRSC_VAL_MODES_B 8'h01

`define IRSC_RST_MAIN0 8'h0F
`define IRSC_RST_MAIN1 8'h00
`define IRSC_RST_MAIN2 8'h70

`define IRSC_LOW_RESET_CLOCKS 30
`define IRSC_TURN_CLOCKS 3
`define IRSC_CLK_PERIOD_NS 4
`define IRSC_SCLK_MIN_PERIOD_NS 125
`define IRSC_SCLK_PERIOD_CYC \
   ((`IRSC_SCLK_MIN_PERIOD_NS + `IRSC_CLK_PERIOD_NS - 1) / `IRSC_CLK_PERIOD_NS)

`define IRSC_REG_CMD 2'h0
`define IRSC_REG_STATUS 2'h1
`define IRSC_REG_RDATA 2'h2
`endif

//--- irsc_pkg.sv
// types shared by both ends of the transceiver serial control link
package irsc_pkg;
   typedef enum logic [2:0] {
      IRSC_CMD_WRITE,
      IRSC_CMD_READ,
      IRSC_CMD_EXT_READ,
      IRSC_CMD_SPECIAL_RESET,
      IRSC_CMD_LINE_RESET
   } irsc_cmd_type;

   typedef enum logic [3:0] {
      DS_IDLE, DS_SYNC, DS_HDR, DS_MARK, DS_DATA, DS_EIDX,
      DS_STOP, DS_ACK, DS_TURN, DS_RESP
   } irsc_dev_state_type;

   typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH} irsc_host_state_type;
endpackage
